// ==== hw/tap_chain.sv ====
// Per-tile test access chain: boundary-scan port followed by chip-access port.
// Assumes the host supplies tck; system side runs on clk with async reset rst.
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - After reset each tile places a boundary-scan port and a chip-access port in the chain.
// - The boundary-scan port follows the standard and scans the device pins.
// - The chip-access port reaches tile, switch and fused memory for loading and debug.
// - The logic serves loading, boundary test, source debug and fused memory programming.
// - While the test reset is low the test logic, apart from the two update toggles, stays in reset.
// - The id instruction selects a 32-bit id word with version, part, maker and bit 0 set.
// - The user code instruction selects a 32-bit word of user tag, unused and revision.
// - The user tag comes from security bits 22 to 31 of tile 0, zero when unfused.
// - The global reset is active low, asserts asynchronously and resets the test-clock side apart from the two toggles, and the boot start.
// - After global reset release the device waits for pll lock before booting.
// - Security bit 0 set disables the test interface entirely.
// - Security bit 13 set blocks every test access to the fused memory.
module tap_chain
   import tap_pkg::*;
#(
   parameter logic [3:0]  VERSION   = 4'h0,     // Arbitrary value
   parameter logic [15:0] PART      = 16'h0001, // Arbitrary value
   parameter logic [10:0] MAKER     = 11'h001,  // Arbitrary value
   parameter logic [11:0] SI_REV    = 12'h001,  // Arbitrary value
   parameter int unsigned BSR_W     = 8
)(
   input  wire logic                clk,        // System clock
   input  wire logic                rst,        // Async system reset, high
   input  wire logic                rst_n,      // Global reset pin, low
   input  wire logic                pll_lock,   // Pll lock indication
   input  wire logic [31:0]         sec_reg,    // Tile 0 security register
   input  wire logic                tck,        // Test clock from host
   input  wire logic                trst_n,     // Test reset, low
   input  wire tap_pkg::link_in_t   link_i,     // Test mode and data in
   output var  tap_pkg::link_out_t  link_o,     // Test data out and enable
   input  wire logic [BSR_W-1:0]    pins_in,    // Pin levels for capture
   output logic [BSR_W-1:0]         pins_out,   // Pin drive values
   output logic                     pins_ext,   // Pins under scan control
   output logic                     boot_go,    // Start boot
   output var  tap_pkg::chip_word_t chip_wr,    // Word from chip port
   output logic                     chip_wr_v   // Word valid, one cycle
);
   import tap_pkg::*;

   // Test-clock domain reset: pin, global reset or disable fuse
   wire        sec_nojtag = sec_reg[SEC_NO_JTAG];
   wire        sec_nojotp = sec_reg[SEC_NO_JOTP];
   wire        tap_rst    = ~trst_n | ~rst_n | sec_nojtag;

   // Two ports in series share one controller sequence each
   tap_state_t st_q [2];
   logic [IR_W-1:0] ir_sh_q [2];
   logic [IR_W-1:0] ir_q    [2];
   logic [DR_W-1:0] dr_q    [2];
   logic [BSR_W-1:0] bsr_q;
   logic [BSR_W-1:0] bsr_upd_q;
   logic [DR_W-1:0]  chip_reg_q;
   logic             chip_tgl_q;
   logic             chip_otp_q;
   logic             tdo_q;
   logic             tdo_oe_q;
   logic [BSR_W-1:0] pin_s1_q;
   logic [BSR_W-1:0] pin_s2_q;
   logic             bsr_tgl_q;
   wire  [1:0]       so;
   wire  [1:0]       si;

   wire [DR_W-1:0] id_word = {VERSION, PART, MAKER, 1'b1};
   wire [UC_TAG_W-1:0] tag = sec_reg[SEC_TAG_LSB +: UC_TAG_W];
   wire [DR_W-1:0] uc_word = {tag, {(UC_TAG_LSB-12){1'b0}}, SI_REV};

   assign si[0] = link_i.tdi;
   assign si[1] = so[0];

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_tap
         tap_state_t nx;
         wire tms = link_i.tms;
         always_comb begin
            unique case (st_q[g])
               ST_RESET:  nx = tms ? ST_RESET  : ST_IDLE;
               ST_IDLE:   nx = tms ? ST_SEL_DR : ST_IDLE;
               ST_SEL_DR: nx = tms ? ST_SEL_IR : ST_CAP_DR;
               ST_CAP_DR: nx = tms ? ST_EX1_DR : ST_SH_DR;
               ST_SH_DR:  nx = tms ? ST_EX1_DR : ST_SH_DR;
               ST_EX1_DR: nx = tms ? ST_UPD_DR : ST_PAU_DR;
               ST_PAU_DR: nx = tms ? ST_EX2_DR : ST_PAU_DR;
               ST_EX2_DR: nx = tms ? ST_UPD_DR : ST_SH_DR;
               ST_UPD_DR: nx = tms ? ST_SEL_DR : ST_IDLE;
               ST_SEL_IR: nx = tms ? ST_RESET  : ST_CAP_IR;
               ST_CAP_IR: nx = tms ? ST_EX1_IR : ST_SH_IR;
               ST_SH_IR:  nx = tms ? ST_EX1_IR : ST_SH_IR;
               ST_EX1_IR: nx = tms ? ST_UPD_IR : ST_PAU_IR;
               ST_PAU_IR: nx = tms ? ST_EX2_IR : ST_PAU_IR;
               ST_EX2_IR: nx = tms ? ST_UPD_IR : ST_SH_IR;
               ST_UPD_IR: nx = tms ? ST_SEL_DR : ST_IDLE;
            endcase
         end

         // Bypass, and the fused-memory register on the second port while blocked, are one bit; boundary is BSR_W bits, the rest full width
         wire one_bit = (ir_q[g] == INS_BYPASS) ||
                        (g == 1 && ir_q[g] == INS_OTPREG && sec_nojotp);
         wire bs_sel  = (g == 0) && (ir_q[g] == INS_EXTEST || ir_q[g] == INS_SAMPLE);
         wire is_id   = (ir_q[g] == INS_DEVICE_IDENTIFICATION_WORD);
         wire is_uc   = (ir_q[g] == INS_USERCODE);
         wire is_chip = (g == 1) && (ir_q[g] == INS_CHIPREG);
         // Unknown codes capture zeros rather than a stale word
         wire [DR_W-1:0] cap = is_id   ? id_word :
                               is_uc   ? uc_word :
                               is_chip ? chip_reg_q :
                               {DR_W{1'b0}};
         assign so[g] = (st_q[g] == ST_SH_IR) ? ir_sh_q[g][0] :
                        one_bit ? dr_q[g][0] :
                        bs_sel  ? bsr_q[0] : dr_q[g][0];

         // State decodes shared by the register blocks below
         wire in_rst = (st_q[g] == ST_RESET);
         wire cap_ir = (st_q[g] == ST_CAP_IR);
         wire sh_ir  = (st_q[g] == ST_SH_IR);
         wire upd_ir = (st_q[g] == ST_UPD_IR);
         wire cap_dr = (st_q[g] == ST_CAP_DR);
         wire sh_dr  = (st_q[g] == ST_SH_DR);
         wire [DR_W-1:0] dr_sh = one_bit ? {{(DR_W-1){1'b0}}, si[g]} :
                                           {si[g], dr_q[g][DR_W-1:1]};

         always_ff @(posedge tck or posedge tap_rst) begin
            if (tap_rst)
               st_q[g] <= ST_RESET;
            else
               st_q[g] <= nx;
         end

         always_ff @(posedge tck or posedge tap_rst) begin
            if (tap_rst)
               ir_sh_q[g] <= '0;
            else if (cap_ir)
               ir_sh_q[g] <= {{(IR_W-2){1'b0}}, 2'b01};
            else if (sh_ir)
               ir_sh_q[g] <= {si[g], ir_sh_q[g][IR_W-1:1]};
         end

         // Test-logic-reset reloads the id instruction, as after power-up
         always_ff @(posedge tck or posedge tap_rst) begin
            if (tap_rst)
               ir_q[g] <= INS_DEVICE_IDENTIFICATION_WORD;
            else if (in_rst)
               ir_q[g] <= INS_DEVICE_IDENTIFICATION_WORD;
            else if (upd_ir)
               ir_q[g] <= ir_sh_q[g];
         end

         always_ff @(posedge tck or posedge tap_rst) begin
            if (tap_rst)
               dr_q[g] <= '0;
            else if (cap_dr)
               dr_q[g] <= cap;
            else if (sh_dr)
               dr_q[g] <= dr_sh;
         end
      end
   endgenerate

   // Boundary register lives on the first port
   wire bs0 = (ir_q[0] == INS_EXTEST || ir_q[0] == INS_SAMPLE);

   // Pins settle through two tck flops before capture
   always_ff @(posedge tck or posedge tap_rst) begin
      if (tap_rst) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
      end else begin
         pin_s1_q <= pins_in;
         pin_s2_q <= pin_s1_q;
      end
   end

   // Toggle hands the drive word to clk; a test reset must not flip it
   wire bsr_upd = bs0 && (st_q[0] == ST_UPD_DR);
   always_ff @(posedge tck or posedge rst) begin
      if (rst)
         bsr_tgl_q <= 1'b0;
      else if (bsr_upd)
         bsr_tgl_q <= ~bsr_tgl_q;
   end

   always_ff @(posedge tck or posedge tap_rst) begin
      if (tap_rst) begin
         bsr_q     <= '0;
         bsr_upd_q <= '0;
      end else if (bs0) begin
         if (st_q[0] == ST_CAP_DR)
            bsr_q <= pin_s2_q;
         else if (st_q[0] == ST_SH_DR)
            bsr_q <= {si[0], bsr_q[BSR_W-1:1]};
         else if (st_q[0] == ST_UPD_DR)
            bsr_upd_q <= bsr_q;
      end
   end

   // Chip port update: latch word, toggle to cross into clk domain
   wire chip_upd = (st_q[1] == ST_UPD_DR) &&
                   (ir_q[1] == INS_CHIPREG ||
                    (ir_q[1] == INS_OTPREG && !sec_nojotp));
   always_ff @(posedge tck or posedge tap_rst) begin
      if (tap_rst) begin
         chip_reg_q <= '0;
         chip_otp_q <= 1'b0;
      end else if (chip_upd) begin
         chip_reg_q <= dr_q[1];
         chip_otp_q <= (ir_q[1] == INS_OTPREG);
      end
   end

   // Reset only by rst: a test reset clearing it would fake a new word
   always_ff @(posedge tck or posedge rst) begin
      if (rst)
         chip_tgl_q <= 1'b0;
      else if (chip_upd)
         chip_tgl_q <= ~chip_tgl_q;
   end

   // Tdo changes on the falling edge, driven only while shifting
   wire shifting = (st_q[1] == ST_SH_DR) || (st_q[1] == ST_SH_IR);
   always_ff @(negedge tck or posedge tap_rst) begin
      if (tap_rst)
         tdo_q <= 1'b0;
      else
         tdo_q <= so[1];
   end

   always_ff @(negedge tck or posedge tap_rst) begin
      if (tap_rst)
         tdo_oe_q <= 1'b0;
      else
         tdo_oe_q <= shifting;
   end
   assign link_o = '{tdo: tdo_q, tdo_oe: tdo_oe_q};

   // System side: scan outputs, chip word crossing, boot gating
   logic [2:0]       tgl_sync_q;
   logic [2:0]       drv_sync_q;
   logic [1:0]       ext_sync_q;
   logic [1:0]       lock_sync_q;
   logic [1:0]       rstn_sync_q;
   chip_word_t       chip_wr_q;
   logic             chip_wr_v_q;
   logic             boot_q;
   logic [BSR_W-1:0] pins_out_q;

   wire ext_now  = (ir_q[0] == INS_EXTEST);
   wire tgl_evt  = tgl_sync_q[2] ^ tgl_sync_q[1];
   // Boot only once the pin reset has gone and the pll has relocked
   wire boot_d   = rstn_sync_q[1] & lock_sync_q[1];
   wire drv_evt  = drv_sync_q[2] ^ drv_sync_q[1];
   // Global reset drops boot at once; its release passes the synchroniser
   wire boot_rst = rst | ~rst_n;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tgl_sync_q <= '0;
         drv_sync_q <= '0;
      end else begin
         tgl_sync_q <= {tgl_sync_q[1:0], chip_tgl_q};
         drv_sync_q <= {drv_sync_q[1:0], bsr_tgl_q};
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ext_sync_q  <= '0;
         lock_sync_q <= '0;
      end else begin
         ext_sync_q  <= {ext_sync_q[0], ext_now};
         lock_sync_q <= {lock_sync_q[0], pll_lock};
      end
   end

   always_ff @(posedge clk or posedge boot_rst) begin
      if (boot_rst) begin
         rstn_sync_q <= '0;
         boot_q      <= 1'b0;
      end else begin
         rstn_sync_q <= {rstn_sync_q[0], 1'b1};
         boot_q      <= boot_d;
      end
   end

   // Chip word changes with the toggle and then holds for many clk cycles, safe to sample
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         chip_wr_q   <= '0;
         chip_wr_v_q <= 1'b0;
      end else begin
         chip_wr_v_q <= tgl_evt;
         if (tgl_evt)
            chip_wr_q <= '{otp_sel: chip_otp_q, data: chip_reg_q};
      end
   end

   // Drive word moves only on a synced update, never while it changes
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         pins_out_q <= '0;
      else if (drv_evt)
         pins_out_q <= bsr_upd_q;
   end

   assign chip_wr   = chip_wr_q;
   assign chip_wr_v = chip_wr_v_q;
   assign boot_go   = boot_q;
   assign pins_out  = pins_out_q;
   assign pins_ext  = ext_sync_q[1];

endmodule

`default_nettype wire

// ==== hw/tap_pkg.sv ====
// Package for the per-tile test access chain: instruction codes, id word layout, timing.
// Assumes a four-wire test link clocked by the host and a 100 MHz system clock.
package tap_pkg;
   localparam int unsigned IR_W          = 4;
   localparam int unsigned DR_W          = 32;
   // Instruction codes
   localparam logic [3:0]  INS_EXTEST    = 4'h0;
   localparam logic [3:0]  INS_SAMPLE    = 4'h1;
   localparam logic [3:0]  INS_DEVICE_IDENTIFICATION_WORD    = 4'h2;
   localparam logic [3:0]  INS_USERCODE  = 4'h3;
   localparam logic [3:0]  INS_CHIPREG   = 4'h8;
   localparam logic [3:0]  INS_OTPREG    = 4'h9;
   localparam logic [3:0]  INS_BYPASS    = 4'hf;
   // Id word fields
   localparam int unsigned ID_VER_LSB    = 28;
   localparam int unsigned ID_PART_LSB   = 12;
   localparam int unsigned ID_MFR_LSB    = 1;
   // User code fields
   localparam int unsigned UC_TAG_LSB    = 22;
   localparam int unsigned UC_TAG_W      = 10;
   // Security bit positions
   localparam int unsigned SEC_NO_JTAG   = 0;
   localparam int unsigned SEC_NO_JOTP   = 13;
   localparam int unsigned SEC_TAG_LSB   = 22;
   // Timing
   localparam int unsigned CLK_MHZ       = 100;
   localparam int unsigned TRST_MIN_NS   = 100;
   localparam int unsigned TRST_MIN_CYC  = (TRST_MIN_NS * CLK_MHZ + 999) / 1000;

   typedef enum logic [3:0] {
      ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR,
      ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR,
      ST_EX2_IR, ST_UPD_IR
   } tap_state_t;

   typedef struct packed {
      logic       tms;
      logic       tdi;
   } link_in_t;

   typedef struct packed {
      logic       tdo;
      logic       tdo_oe;
   } link_out_t;

   // Word handed from the test clock domain to the chip side
   typedef struct packed {
      logic       otp_sel;
      logic [DR_W-1:0] data;
   } chip_word_t;
endpackage

// ==== test/tap_chain_sva.sv ====
// Port checker for the test access chain.
// Assumes it is bound into tap_chain and tck stands still between frames.
`timescale 1ns/1ns
`default_nettype none
module tap_chain_sva
   import tap_pkg::*;
(
   input wire logic                clk,       // System clock
   input wire logic                rst,       // Async reset
   input wire logic                rst_n,     // Global reset
   input wire logic                pll_lock,  // Pll lock
   input wire logic [31:0]         sec_reg,   // Security bits
   input wire logic                tck,       // Test clock
   input wire logic                trst_n,    // Test reset
   input wire tap_pkg::link_in_t   link_i,    // Tms and tdi
   input wire tap_pkg::link_out_t  link_o,    // Tdo and enable
   input wire logic                boot_go,   // Boot start
   input wire tap_pkg::chip_word_t chip_wr,   // Chip word
   input wire logic                chip_wr_v  // Word valid
);
   // Any of these holds the tck side in reset
   wire tck_off = !trst_n || !rst_n || sec_reg[SEC_NO_JTAG];
   sequence boot_ready;
      (rst_n && pll_lock) [*5];
   endsequence
   a_boot_waits_lock: assert property (@(posedge clk) disable iff (rst)
      (!pll_lock) [*4] |=> !boot_go) else $error("boot started without lock");
   a_boot_on_ready: assert property (@(posedge clk) disable iff (rst)
      boot_ready |-> boot_go) else $error("boot missing after lock");
   a_boot_held_reset: assert property (@(posedge clk) disable iff (rst)
      (!rst_n) [*4] |=> !boot_go) else $error("boot during global reset");
   a_test_reset_quiet: assert property (@(posedge clk) disable iff (rst)
      !trst_n |-> !link_o.tdo_oe && !link_o.tdo) else $error("tdo active in reset");
   a_locked_quiet: assert property (@(posedge clk) disable iff (rst)
      sec_reg[SEC_NO_JTAG] |-> !link_o.tdo_oe && !chip_wr_v) else $error("locked port active");
   a_otp_blocked: assert property (@(posedge clk) disable iff (rst)
      sec_reg[SEC_NO_JOTP] |-> !(chip_wr_v && chip_wr.otp_sel)) else $error("fused write");
   a_pulse_single: assert property (@(posedge clk) disable iff (rst)
      chip_wr_v |=> !chip_wr_v) else $error("word valid too long");
   a_shift_entry: assert property (@(posedge tck) disable iff (tck_off)
      $rose(link_o.tdo_oe) |-> $past(link_i.tms) == 1'b0 && $past(link_i.tms, 2) == 1'b0)
      else $error("shift entered wrongly");
   a_shift_exit: assert property (@(posedge tck) disable iff (tck_off)
      $fell(link_o.tdo_oe) |-> $past(link_i.tms)) else $error("shift left wrongly");
endmodule
bind tap_chain tap_chain_sva tap_chain_sva_inst (.clk, .rst, .rst_n, .pll_lock, .sec_reg,
   .tck, .trst_n, .link_i, .link_o, .boot_go, .chip_wr, .chip_wr_v);
`default_nettype wire

// ==== test/jtag_host.sv ====
// Host side of the four-wire test link; tck runs only inside a frame.
// Assumes the chain samples tms/tdi on tck rise and moves tdo on tck fall.
`timescale 1ns/1ns
`default_nettype none
module jtag_host
   import tap_pkg::*;
(
   output logic                    tck,    // Test clock, idle low
   output tap_pkg::link_in_t       link_i, // Tms and tdi
   input  wire tap_pkg::link_out_t link_o  // Tdo from chain
);
   initial begin
      tck = 1'b0;
      link_i = '0;
   end
   // Edge i carries tms[i], tdi[i]; tdo taken at the same rise
   task automatic frame(input logic [79:0] tms, tdi, input int n, output logic [79:0] tdo);
      tdo = '0;
      #3;
      for (int i = 0; i < n; i++) begin
         link_i = {tms[i], tdi[i]};
         #7 tck = 1'b1;
         tdo[i] = link_o.tdo;
         #8 tck = 1'b0;
      end
      // Stale tdi must not pass for valid data
      link_i.tdi = ~link_i.tdi;
   endtask
endmodule
`default_nettype wire

// ==== test/tap_chain_tb.sv ====
// Self-checking bench for tap_chain with a host model on the test link.
// Assumes default id parameters and an 8-pin boundary register.
`timescale 1ns/1ns
`default_nettype none
module tap_chain_tb;
   import tap_pkg::*;
   localparam logic [31:0] ID = 32'h0000_1003;
   logic       clk, rst, rst_n, pll_lock, trst_n, tck, chip_wr_v, boot_go, pins_ext;
   logic [31:0] sec_reg, d;
   logic [7:0] pins_in, pins_out;
   logic [79:0] o;
   link_in_t   link_i;
   link_out_t  link_o;
   chip_word_t chip_wr, w;
   int         seed = 32'h0397, err_count = 0, comparisons = 0;
   bit         hit;
   tap_chain tap_chain_inst (.clk, .rst, .rst_n, .pll_lock, .sec_reg, .tck, .trst_n,
      .link_i, .link_o, .pins_in, .pins_out, .pins_ext, .boot_go, .chip_wr, .chip_wr_v);
   jtag_host jtag_host_inst (.tck, .link_i, .link_o);
   initial clk = 1'b0;
   always #5 clk = ~clk;
   task automatic chk(input string nm, input logic [63:0] e, g);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask
   // From idle to idle: ir=1 instruction scan, ir=0 data scan of n bits
   task automatic scan(input int ir, n, input logic [79:0] din);
      int k;
      k = ir + 1;
      jtag_host_inst.frame((80'h3 << (k+n+2)) | (((80'h1 << k) - 1) << 1), din << (k+3),
         k+n+5, o);
      o = (o >> (k+3)) & ((80'h1 << n) - 1);
   endtask
   task automatic clks(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wait_word;
      hit = 0;
      for (int i = 0; i < 20 && !hit; i++) begin
         @(negedge clk);
         hit = (chip_wr_v === 1'b1);
         w = chip_wr;
      end
      @(negedge clk);
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      {rst, rst_n, trst_n, pll_lock, sec_reg, pins_in} = {3'b100, 41'h0};
      clks(4);
      rst = 0;
      clks(8);
      {rst_n, trst_n} = 2'b11;
      clks(8);
      chk("boot before lock", 0, boot_go);
      pll_lock = 1;
      clks(6);
      chk("boot after lock", 1, boot_go);
      scan(0, 64, '0);
      chk("id chain", {ID, ID}, o[63:0]);
      scan(1, 8, 80'hf3);
      chk("ir capture", 8'h11, o[63:0]);
      for (int i = 0; i < 4; i++) begin
         @(negedge clk);
         sec_reg = (i == 0) ? '0 : $random(seed) & 32'hffff_fffe;
         scan(0, 33, '0);
         chk("usercode", {1'b0, sec_reg[31:22], 22'h1}, o[63:0]);
      end
      $display("id and usercode done");
      for (int i = 0; i < 3; i++) begin
         @(negedge clk);
         sec_reg = 32'(i == 2) << 13;
         d = $random(seed);
         scan(1, 8, (i == 0) ? 80'hf8 : 80'hf9);
         scan(0, 33, d);
         wait_word;
         chk("word pulse", i < 2, hit);
         if (hit)
            chk("word", {i == 1, d}, w);
         if (i == 0) begin
            scan(0, 33, '0);
            chk("chip readback", d, o[31:0]);
            wait_word;
         end
      end
      $display("chip and fused words done");
      @(negedge clk);
      {sec_reg, pins_in, d} = {32'h0, 8'($random(seed)), 32'($random(seed))};
      scan(1, 8, 80'h0f);
      scan(0, 9, {d[7:0], 1'b0});
      chk("pin capture", {pins_in, 1'b0}, o[63:0]);
      clks(6);
      chk("pin drive", {1'b1, d[7:0]}, {pins_ext, pins_out});
      $display("boundary scan done");
      @(negedge clk);
      sec_reg = 32'h1;
      scan(0, 64, {2{32'hffff_ffff}});
      chk("locked tdo", 0, o[63:0]);
      @(negedge clk);
      sec_reg = '0;
      for (int r = 0; r < 2; r++) begin
         scan(1, 8, 80'hff);
         @(negedge clk);
         {trst_n, rst_n} = r ? 2'b01 : 2'b10;
         clks(10);
         chk("boot in reset", r, boot_go);
         {trst_n, rst_n} = 2'b11;
         scan(0, 64, '0);
         chk("id after reset", {ID, ID}, o[63:0]);
      end
      $display("lock and resets done");
      tally_and_finish;
   end
endmodule
`default_nettype wire
